// ---- core/dsa_pkg.sv ----
package dsa_pkg;
	// register byte offsets
	localparam logic [5:0] DSA_OFS_CTRL = 6'h00;
	localparam logic [5:0] DSA_OFS_STAT = 6'h04;
	localparam logic [5:0] DSA_OFS_FSEL = 6'h08;
	// control register fields
	localparam int DSA_CTRL_TOOL_EXCL = 0;
	localparam int DSA_CTRL_TOOL_RST = 1;
	localparam int DSA_CTRL_SW_EN = 2;
	localparam int DSA_CTRL_QSTOP = 3;
	localparam int DSA_CTRL_LOAD_DFLT = 4;
	localparam int DSA_CTRL_CLR_REFUSE = 5;
	localparam int DSA_CTRL_MODE_LSB = 8;
	localparam logic [31:0] DSA_CTRL_RST = 32'h0000_0000;
	// status register fields
	localparam int DSA_STAT_STATE_LSB = 0;
	localparam int DSA_STAT_OWNER_LSB = 4;
	localparam int DSA_STAT_ERRMSG = 6;
	localparam int DSA_STAT_REFUSED = 7;
	localparam int DSA_STAT_PULSE = 8;
	// input function codes
	localparam logic [7:0] DSA_FN_NONE = 8'h00;
	localparam logic [7:0] DSA_FN_SON = 8'h01;
	localparam logic [7:0] DSA_FN_FRST = 8'h02;
	localparam logic [7:0] DSA_FN_CLRDEV = 8'h04;
	localparam logic [7:0] DSA_FN_REV = 8'h06;
	localparam logic [7:0] DSA_FN_HALT = 8'h07;
	localparam logic [7:0] DSA_FN_TRIG = 8'h08;
	localparam logic [7:0] DSA_FN_TRQLM = 8'h09;
	localparam logic [7:0] DSA_FN_SPDLM = 8'h10;
	localparam logic [7:0] DSA_FN_POS0 = 8'h11;
	localparam logic [7:0] DSA_FN_POS1 = 8'h12;
	localparam logic [7:0] DSA_FN_SPD0 = 8'h14;
	localparam logic [7:0] DSA_FN_SPD1 = 8'h15;
	localparam logic [7:0] DSA_FN_TCM0 = 8'h16;
	localparam logic [7:0] DSA_FN_TCM1 = 8'h17;
	localparam logic [7:0] DSA_FN_VP = 8'h18;
	localparam logic [7:0] DSA_FN_VT = 8'h19;
	localparam logic [7:0] DSA_FN_TP = 8'h20;
	localparam logic [7:0] DSA_FN_STOPDIS = 8'h21;
	localparam logic [7:0] DSA_FN_NLIM = 8'h22;
	localparam logic [7:0] DSA_FN_PLIM = 8'h23;
	// operating modes, single and dual
	typedef enum logic [3:0] {
		DSA_M_PT, DSA_M_PS, DSA_M_V, DSA_M_T, DSA_M_VZ, DSA_M_TZ,
		DSA_M_PTV, DSA_M_PTT, DSA_M_PSV, DSA_M_PST, DSA_M_VT
	} dsa_mode_e;
	// operating states, code is position plus one
	typedef enum logic [3:0] {
		DSA_ST_START, DSA_ST_NOT_READY, DSA_ST_SW_ON_DIS, DSA_ST_READY,
		DSA_ST_SWITCHED_ON, DSA_ST_OP_EN, DSA_ST_QSTOP, DSA_ST_FAULT_REACT,
		DSA_ST_FAULT
	} dsa_state_e;
	// exclusive access owner
	typedef enum logic [1:0] {DSA_OWN_NONE, DSA_OWN_PANEL, DSA_OWN_TOOL} dsa_owner_e;
	// drive-side flags carried together
	typedef struct packed {
		logic power_on;
		logic run_mode;
		logic ready;
		logic qstop;
		logic fault_react;
		logic fault;
		logic halt;
		logic reverse;
		logic neg_lim;
		logic pos_lim;
	} dsa_drive_s;
endpackage

// ---- core/dsa_drive_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
// Operation
// - at most one channel holds exclusive access
// - no exclusive owner after power-on
// - analog and pulse references effective at power-on
// - pulse inputs ignored during exclusive access
// - halt, fault reset, servo-off, limits stay effective
// - tool switch on grants tool exclusivity
// - panel jog/autotune start grants panel exclusivity
// - nine operating states numbered one to nine
// - state 3 refuses power stage enable
// - state 4 reports ready to switch on
// - state 6 enables stage, runs mode
// - state 7 quick stop, state 8 error response
// - state 9 keeps power stage disabled
// - fault reset edge or tool clears error
// - servo-on rising edge also clears error, only with no exclusive owner
// - inputs carry coded, mode-dependent functions
// - mode defaults preload, servo-on on input 1
// - code 06 input reverses rotation
// - each function on one input only
// - servo-on enables only without detected errors
module dsa_drive_ctrl
	import dsa_pkg::*;
#(
	parameter int NUM_DI = 8 // digital signal inputs
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_DI-1:0] di_pin,
	input wire logic pulse_pin,
	input wire logic supply_ok,
	input wire logic error_detect,
	input wire logic motion_stopped,
	input wire logic panel_mode_start,
	input wire logic panel_mode_end,
	output dsa_drive_s drive_out,
	output logic pulse_pass,
	output logic ref_effective
);
	dsa_state_e st_reg, st_next; // operating state
	dsa_owner_e owner_reg, owner_next; // exclusive owner
	logic [31:0] ctrl_reg; // control word
	logic [7:0] fsel_reg [NUM_DI]; // function per input
	logic [NUM_DI-1:0] di_s1_reg, di_s2_reg; // input synchroniser
	logic pulse_s1_reg, pulse_s2_reg; // pulse synchroniser
	logic son_q_reg, frst_q_reg; // previous function levels
	logic err_msg_reg; // pending error message
	logic refused_reg; // sticky: enable or select refused
	logic tool_rst_reg; // one-cycle tool reset pulse
	logic son_off_reg; // servo-off seen while on; enable must drop first
	logic acc, wr_acc; // bus access taken this edge
	logic son_lvl, frst_lvl, son_rise, son_fall, frst_rise;
	logic en_hold, clr_req, sel_hit;
	logic [31:0] rd_mux;

	// true when any input assigned to code is active
	function automatic logic fn_on(input logic [7:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_DI; i++) begin
			if (fsel_reg[i] == code && di_s2_reg[i]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// true when another input already carries code
	function automatic logic code_used(input logic [7:0] code, input int idx);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_DI; i++) begin
			if (i != idx && code != DSA_FN_NONE && fsel_reg[i] == code) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// default function of input idx in mode m
	function automatic logic [7:0] dflt(input logic [3:0] m, input int idx);
		logic [7:0] r;
		logic pos, trq, vel;
		r = DSA_FN_NONE;
		pos = (m == DSA_M_PS || m == DSA_M_PSV || m == DSA_M_PST);
		trq = (m == DSA_M_T || m == DSA_M_TZ || m == DSA_M_PT || m == DSA_M_PTT);
		vel = (m == DSA_M_V || m == DSA_M_VZ || m == DSA_M_PTV || m == DSA_M_VT);
		case (idx)
			0: r = DSA_FN_SON;
			1: begin
				if (m == DSA_M_PT || m == DSA_M_PTV || m == DSA_M_PTT) begin
					r = DSA_FN_CLRDEV;
				end else if (pos) begin
					r = DSA_FN_TRIG;
				end else if (m == DSA_M_V || m == DSA_M_VZ) begin
					r = DSA_FN_TRQLM;
				end else if (m == DSA_M_T || m == DSA_M_TZ) begin
					r = DSA_FN_SPDLM;
				end
			end
			2: r = pos ? DSA_FN_POS0 : (vel ? DSA_FN_SPD0 : (trq ? DSA_FN_TCM0 : DSA_FN_NONE));
			3: r = pos ? DSA_FN_POS1 : (vel ? DSA_FN_SPD1 : (trq ? DSA_FN_TCM1 : DSA_FN_NONE));
			4: r = (m == DSA_M_PSV) ? DSA_FN_SPD0 : ((m == DSA_M_VT) ? DSA_FN_TCM0 : DSA_FN_FRST);
			5: r = (m == DSA_M_PSV) ? DSA_FN_SPD1 : ((m == DSA_M_VT) ? DSA_FN_TCM1 : DSA_FN_NLIM);
			6: begin
				if (m == DSA_M_PTV || m == DSA_M_PSV) begin
					r = DSA_FN_VP;
				end else if (m == DSA_M_VT) begin
					r = DSA_FN_VT;
				end else if (m == DSA_M_PTT || m == DSA_M_PST) begin
					r = DSA_FN_TP;
				end else begin
					r = DSA_FN_PLIM;
				end
			end
			7: r = DSA_FN_STOPDIS;
			default: r = DSA_FN_NONE;
		endcase
		return r;
	endfunction

	// bus: one wait cycle, access completes when waitrequest is low
	assign acc = clk_en && (avs_read || avs_write) && !avs_waitrequest;
	assign wr_acc = acc && avs_write;

	// input function levels and edges, on synchronised inputs only
	// a process, so the select table read inside the function is in its sensitivity
	always_comb begin
		son_lvl = fn_on(DSA_FN_SON);
		frst_lvl = fn_on(DSA_FN_FRST);
	end
	assign son_rise = son_lvl && !son_q_reg;
	assign son_fall = !son_lvl && son_q_reg;
	assign frst_rise = frst_lvl && !frst_q_reg;
	// servo-on rising edge counts only when no channel is exclusive
	assign clr_req = frst_rise || tool_rst_reg || (son_rise && owner_reg == DSA_OWN_NONE);
	// an exclusive channel enables through its own control bit
	assign en_hold = (owner_reg == DSA_OWN_NONE) ? son_lvl : ctrl_reg[DSA_CTRL_SW_EN];

	// two-stage synchronisers for pins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			di_s1_reg <= '0;
			di_s2_reg <= '0;
			pulse_s1_reg <= 1'b0;
			pulse_s2_reg <= 1'b0;
		end else if (clk_en) begin
			di_s1_reg <= di_pin;
			di_s2_reg <= di_s1_reg;
			pulse_s1_reg <= pulse_pin;
			pulse_s2_reg <= pulse_s1_reg;
		end
	end

	// edge history of servo-on and fault reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			son_q_reg <= 1'b0;
			frst_q_reg <= 1'b0;
		end else if (clk_en) begin
			son_q_reg <= son_lvl;
			frst_q_reg <= frst_lvl;
		end
	end

	// servo-off memory: a still-held software enable must not undo a servo-off edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			son_off_reg <= 1'b0;
		end else if (clk_en) begin
			if (son_fall && st_reg inside {DSA_ST_SWITCHED_ON, DSA_ST_OP_EN}) begin
				son_off_reg <= 1'b1;
			end else if (!en_hold) begin
				son_off_reg <= 1'b0;
			end
		end
	end

	// exclusive access arbitration, tool wins a tie
	always_comb begin
		owner_next = owner_reg;
		case (owner_reg)
			DSA_OWN_NONE: begin
				if (ctrl_reg[DSA_CTRL_TOOL_EXCL]) begin
					owner_next = DSA_OWN_TOOL;
				end else if (panel_mode_start) begin
					owner_next = DSA_OWN_PANEL;
				end
			end
			// a holder keeps it until it lets go; no takeover
			DSA_OWN_PANEL: if (panel_mode_end) begin
				owner_next = DSA_OWN_NONE;
			end
			DSA_OWN_TOOL: if (!ctrl_reg[DSA_CTRL_TOOL_EXCL]) begin
				owner_next = DSA_OWN_NONE;
			end
			default: owner_next = DSA_OWN_NONE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			owner_reg <= DSA_OWN_NONE;
		end else if (clk_en) begin
			owner_reg <= owner_next;
		end
	end

	// operating state machine
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			DSA_ST_START: st_next = DSA_ST_NOT_READY;
			DSA_ST_NOT_READY: if (supply_ok) begin
				st_next = DSA_ST_SW_ON_DIS;
			end
			// a held enable must drop before readiness, so it cannot slip through
			DSA_ST_SW_ON_DIS: begin
				if (error_detect) begin
					st_next = DSA_ST_FAULT;
				end else if (!en_hold && !ctrl_reg[DSA_CTRL_QSTOP]) begin
					st_next = DSA_ST_READY;
				end
			end
			DSA_ST_READY: begin
				if (error_detect) begin
					st_next = DSA_ST_FAULT;
				end else if (en_hold && !son_off_reg) begin
					st_next = DSA_ST_SWITCHED_ON;
				end
			end
			DSA_ST_SWITCHED_ON: begin
				if (error_detect) begin
					st_next = DSA_ST_FAULT_REACT;
				end else if (!en_hold || son_fall) begin
					st_next = DSA_ST_READY;
				end else begin
					st_next = DSA_ST_OP_EN;
				end
			end
			DSA_ST_OP_EN: begin
				if (error_detect) begin
					st_next = DSA_ST_FAULT_REACT;
				end else if (ctrl_reg[DSA_CTRL_QSTOP]) begin
					st_next = DSA_ST_QSTOP;
				end else if (!en_hold || son_fall) begin
					st_next = DSA_ST_READY;
				end
			end
			DSA_ST_QSTOP: begin
				if (error_detect) begin
					st_next = DSA_ST_FAULT_REACT;
				end else if (motion_stopped) begin
					st_next = DSA_ST_SW_ON_DIS;
				end
			end
			DSA_ST_FAULT_REACT: if (motion_stopped) begin
				st_next = DSA_ST_FAULT;
			end
			// leave only once the cause is gone
			DSA_ST_FAULT: if (clr_req && !error_detect) begin
				st_next = DSA_ST_SW_ON_DIS;
			end
			default: st_next = DSA_ST_START;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_reg <= DSA_ST_START;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// error message: detection sets, a clean reset edge clears; set wins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			err_msg_reg <= 1'b0;
		end else if (clk_en) begin
			if (error_detect) begin
				err_msg_reg <= 1'b1;
			end else if (clr_req) begin
				err_msg_reg <= 1'b0;
			end
		end
	end

	// control word; the tool reset bit makes a single pulse
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_reg <= DSA_CTRL_RST;
			tool_rst_reg <= 1'b0;
		end else if (clk_en) begin
			tool_rst_reg <= wr_acc && avs_address == DSA_OFS_CTRL && avs_writedata[DSA_CTRL_TOOL_RST];
			if (wr_acc && avs_address == DSA_OFS_CTRL) begin
				ctrl_reg <= avs_writedata;
				ctrl_reg[DSA_CTRL_TOOL_RST] <= 1'b0;
				ctrl_reg[DSA_CTRL_LOAD_DFLT] <= 1'b0;
				ctrl_reg[DSA_CTRL_CLR_REFUSE] <= 1'b0;
			end
		end
	end

	// function selection per input; duplicates are refused
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_DI; i++) begin
				fsel_reg[i] <= dflt(DSA_CTRL_RST[DSA_CTRL_MODE_LSB +: 4], i);
			end
		end else if (clk_en && wr_acc) begin
			if (avs_address == DSA_OFS_CTRL && avs_writedata[DSA_CTRL_LOAD_DFLT]) begin
				for (int i = 0; i < NUM_DI; i++) begin
					fsel_reg[i] <= dflt(avs_writedata[DSA_CTRL_MODE_LSB +: 4], i);
				end
			end
			for (int i = 0; i < NUM_DI; i++) begin
				if (avs_address == DSA_OFS_FSEL + 6'(4 * i)
						&& !code_used(avs_writedata[7:0], i)) begin
					fsel_reg[i] <= avs_writedata[7:0];
				end
			end
		end
	end

	// a duplicate select write hits this
	always_comb begin
		sel_hit = 1'b0;
		for (int i = 0; i < NUM_DI; i++) begin
			if (avs_address == DSA_OFS_FSEL + 6'(4 * i) && code_used(avs_writedata[7:0], i)) begin
				sel_hit = 1'b1;
			end
		end
	end

	// sticky refusal flag; new refusal wins over the clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refused_reg <= 1'b0;
		end else if (clk_en) begin
			if ((wr_acc && sel_hit) || (st_reg == DSA_ST_SW_ON_DIS && son_rise)) begin
				refused_reg <= 1'b1;
			end else if (wr_acc && avs_address == DSA_OFS_CTRL
					&& avs_writedata[DSA_CTRL_CLR_REFUSE]) begin
				refused_reg <= 1'b0;
			end
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address == DSA_OFS_CTRL) begin
			rd_mux = ctrl_reg;
		end else if (avs_address == DSA_OFS_STAT) begin
			rd_mux[DSA_STAT_STATE_LSB +: 4] = 4'(st_reg) + 4'h1;
			rd_mux[DSA_STAT_OWNER_LSB +: 2] = owner_reg;
			rd_mux[DSA_STAT_ERRMSG] = err_msg_reg;
			rd_mux[DSA_STAT_REFUSED] = refused_reg;
			rd_mux[DSA_STAT_PULSE] = pulse_pass;
		end
		for (int i = 0; i < NUM_DI; i++) begin
			if (avs_address == DSA_OFS_FSEL + 6'(4 * i)) begin
				rd_mux[7:0] = fsel_reg[i];
			end
		end
	end

	// bus handshake: waitrequest drops one cycle after a request
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	// drive-side outputs, all registered
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			drive_out <= '0;
			pulse_pass <= 1'b0;
			ref_effective <= 1'b0;
		end else if (clk_en) begin
			ref_effective <= 1'b1;
			pulse_pass <= pulse_s2_reg && owner_reg == DSA_OWN_NONE;
			drive_out.power_on <= st_reg inside {DSA_ST_SWITCHED_ON, DSA_ST_OP_EN,
				DSA_ST_QSTOP, DSA_ST_FAULT_REACT};
			drive_out.run_mode <= st_reg == DSA_ST_OP_EN;
			drive_out.ready <= st_reg == DSA_ST_READY;
			drive_out.qstop <= st_reg == DSA_ST_QSTOP;
			drive_out.fault_react <= st_reg == DSA_ST_FAULT_REACT;
			drive_out.fault <= st_reg == DSA_ST_FAULT;
			drive_out.halt <= fn_on(DSA_FN_HALT);
			drive_out.neg_lim <= fn_on(DSA_FN_NLIM);
			drive_out.pos_lim <= fn_on(DSA_FN_PLIM);
			// direction inversion is not kept during exclusive access
			drive_out.reverse <= fn_on(DSA_FN_REV) && owner_reg == DSA_OWN_NONE;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_PANEL_KEEPS: assert property (
		owner_reg == DSA_OWN_PANEL && clk_en && !panel_mode_end |=> owner_reg == DSA_OWN_PANEL)
		else $error("panel exclusivity lost");
	AST_NO_OWNER_RESET: assert property (disable iff (1'b0)
		reset |=> owner_reg == DSA_OWN_NONE && !ref_effective)
		else $error("owner after reset");
	AST_REF_ON: assert property (disable iff (1'b0)
		reset ##1 !reset && clk_en |=> ref_effective)
		else $error("references not effective after reset");
	AST_PULSE_BLOCK: assert property (
		owner_reg != DSA_OWN_NONE && clk_en |=> !pulse_pass)
		else $error("pulse passed during exclusivity");
	AST_TOOL_GRANT: assert property (
		owner_reg == DSA_OWN_NONE && ctrl_reg[DSA_CTRL_TOOL_EXCL] && clk_en |=> owner_reg == DSA_OWN_TOOL)
		else $error("tool not granted");
	AST_STAGE_OFF_3: assert property (
		st_reg == DSA_ST_SW_ON_DIS && clk_en |=> !drive_out.power_on)
		else $error("stage on in state 3");
	AST_RUN_6: assert property (
		st_reg == DSA_ST_OP_EN && clk_en |=> drive_out.run_mode && drive_out.power_on)
		else $error("state 6 not running");
	AST_FAULT_OFF: assert property (
		st_reg == DSA_ST_FAULT && clk_en |=> !drive_out.power_on && drive_out.fault)
		else $error("stage on in fault");
	AST_NO_EN_ERR: assert property (
		error_detect && clk_en && st_reg != DSA_ST_OP_EN |=> st_reg != DSA_ST_OP_EN)
		else $error("enabled despite error");
	AST_FAULT_EXIT: assert property (
		$past(st_reg) == DSA_ST_FAULT && st_reg != DSA_ST_FAULT |-> st_reg == DSA_ST_SW_ON_DIS)
		else $error("fault left to wrong state");
	AST_BUS_ANSWER: assert property (
		(avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("bus not answered");

	COV_OP_EN: cover property (st_reg == DSA_ST_READY ##[1:20] st_reg == DSA_ST_OP_EN);
	COV_FAULT_CLR: cover property (st_reg == DSA_ST_FAULT ##1 st_reg == DSA_ST_SW_ON_DIS);
	COV_TOOL: cover property (owner_reg == DSA_OWN_TOOL);
	COV_PANEL: cover property (owner_reg == DSA_OWN_PANEL);
endmodule
`default_nettype wire

// ---- tb/dsa_motion_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// far-side motion controller: puts the bench's requested levels onto the signal inputs
module dsa_motion_host (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] di_req, // levels wanted on inputs 1..8
	input wire logic pulse_req, // pulse reference level wanted
	input wire logic err_req, // error cause present at the machine
	output logic [7:0] di_pin,
	output logic pulse_pin,
	output logic error_detect
);
	// the error cause follows the request one cycle late, like a real sensor path
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			error_detect <= 1'b0;
		end else begin
			error_detect <= err_req;
		end
	end
	// fault reset (input 5) is held low until the cause is gone, so the cause is removed first
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			di_pin <= 8'h00;
		end else begin
			di_pin <= di_req & ~{3'h0, err_req | error_detect, 4'h0};
		end
	end
	// pulse line stands low outside a burst
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pulse_pin <= 1'b0;
		end else begin
			pulse_pin <= pulse_req;
		end
	end
endmodule
`default_nettype wire

// ---- tb/drive_state_and_input_access_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module drive_state_and_input_access_test;
	import dsa_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1; // held for six cycles at start
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] di_req = 8'h00; // bench's wish for the inputs
	logic [7:0] di_pin;
	logic pulse_req = 1'b0;
	logic pulse_pin;
	logic err_req = 1'b0;
	logic error_detect;
	logic supply_ok = 1'b0;
	logic motion_stopped = 1'b0;
	logic panel_mode_start = 1'b0;
	logic panel_mode_end = 1'b0;
	dsa_drive_s drive_out;
	logic pulse_pass;
	logic ref_effective;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [31:0] lfsr = 32'h11D2;
	logic [31:0] rd; // data of the last bus read
	logic [7:0] fsel_m [8]; // model of the function selects
	logic [7:0] di2_dflt [11] = '{8'h04, 8'h08, 8'h09, 8'h10, 8'h09, 8'h10, 8'h04, 8'h04, 8'h08, 8'h08, 8'h00};
	logic [7:0] pool [8] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h22, 8'h23, 8'h00};

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	dsa_drive_ctrl u_dsa_drive_ctrl (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.di_pin(di_pin), .pulse_pin(pulse_pin), .supply_ok(supply_ok), .error_detect(error_detect),
		.motion_stopped(motion_stopped), .panel_mode_start(panel_mode_start),
		.panel_mode_end(panel_mode_end), .drive_out(drive_out), .pulse_pass(pulse_pass),
		.ref_effective(ref_effective));

	dsa_motion_host u_dsa_motion_host (.sys_clk(sys_clk), .reset(reset), .di_req(di_req),
		.pulse_req(pulse_req), .err_req(err_req), .di_pin(di_pin), .pulse_pin(pulse_pin),
		.error_detect(error_detect));

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// verdict and end of run, the only exit
	task automatic end_sim;
		if (errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// hang guard: the sequence needs a few hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			end_sim();
		end
	end

	// one Avalon transfer; held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			errors++;
		end
	endtask

	task automatic wrf(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	// poll the state code, bounded, then compare
	task automatic state_is(input logic [3:0] s);
		int n;
		n = 0;
		do begin
			bus(1'b0, DSA_OFS_STAT, 32'h0);
			n++;
		end while (rd[3:0] !== s && n < 40);
		`CHK(rd[3:0], s)
	endtask

	// an input change needs the host flop, two sync flops and the output flop
	task automatic settle;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic set_di(input int b, input logic v);
		@(posedge sys_clk);
		di_req[b] <= v;
		settle();
	endtask

	task automatic panel(input logic st);
		@(posedge sys_clk);
		if (st) panel_mode_start <= 1'b1;
		else panel_mode_end <= 1'b1;
		@(posedge sys_clk);
		panel_mode_start <= 1'b0;
		panel_mode_end <= 1'b0;
		settle();
	endtask

	// error while running, then the reaction ends at standstill
	task automatic fault_to_9;
		set_di(0, 1'b0);
		state_is(4'h4);
		set_di(0, 1'b1);
		state_is(4'h6);
		err_req <= 1'b1;
		state_is(4'h8);
		`CHK(drive_out.fault_react, 1'b1)
		motion_stopped <= 1'b1;
		state_is(4'h9);
		motion_stopped <= 1'b0;
	endtask

	initial begin
		int i;
		logic [7:0] c;
		logic hit;
		repeat (6) @(posedge sys_clk);
		`CHK(ref_effective, 1'b0)
		reset <= 1'b0;
		pulse_req <= 1'b1;
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[5:0], 6'h02)
		`CHK(ref_effective, 1'b1)
		settle();
		`CHK(pulse_pass, 1'b1)
		supply_ok <= 1'b1;
		state_is(4'h4);
		`CHK(drive_out.ready, 1'b1)
		set_di(0, 1'b1);
		state_is(4'h6);
		`CHK({drive_out.power_on, drive_out.run_mode}, 2'b11)
		// reverse on a free input, then a duplicate code that must bounce
		wrf(6'h0C, 32'h06);
		set_di(1, 1'b1);
		`CHK(drive_out.reverse, 1'b1)
		wrf(6'h10, 32'h06);
		rd_chk(6'h10, 32'h16);
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[7], 1'b1)
		di_req[1] <= 1'b0;
		// tool takes over with software enable kept on, refused flag cleared
		wrf(DSA_OFS_CTRL, 32'h25);
		settle();
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[8:4], 5'h02)
		`CHK(pulse_pass, 1'b0)
		panel(1'b1);
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[5:4], 2'h2)
		wrf(6'h24, 32'h07);
		set_di(7, 1'b1);
		set_di(6, 1'b1);
		`CHK({drive_out.halt, drive_out.pos_lim}, 2'b11)
		di_req[7:6] <= 2'b00;
		set_di(5, 1'b1);
		`CHK(drive_out.neg_lim, 1'b1)
		set_di(5, 1'b0);
		set_di(0, 1'b0);
		state_is(4'h4);
		wrf(DSA_OFS_CTRL, 32'h0);
		settle();
		`CHK(pulse_pass, 1'b1)
		// panel start, tool must not steal it
		panel(1'b1);
		wrf(DSA_OFS_CTRL, 32'h1);
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[5:4], 2'h1)
		wrf(DSA_OFS_CTRL, 32'h0);
		panel(1'b0);
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[5:4], 2'h0)
		// quick stop, then a servo-on edge in state 3 is refused
		set_di(0, 1'b1);
		state_is(4'h6);
		wrf(DSA_OFS_CTRL, 32'h08);
		state_is(4'h7);
		`CHK(drive_out.qstop, 1'b1)
		motion_stopped <= 1'b1;
		state_is(4'h3);
		motion_stopped <= 1'b0;
		set_di(0, 1'b0);
		set_di(0, 1'b1);
		bus(1'b0, DSA_OFS_STAT, 32'h0);
		`CHK(rd[7:0], 8'h83)
		`CHK(drive_out.power_on, 1'b0)
		wrf(DSA_OFS_CTRL, 32'h20);
		// fault cleared by servo-on edge; tool reset with cause present does nothing
		fault_to_9();
		`CHK({drive_out.power_on, drive_out.fault}, 2'b01)
		wrf(DSA_OFS_CTRL, 32'h02);
		state_is(4'h9);
		err_req <= 1'b0;
		set_di(0, 1'b0);
		set_di(0, 1'b1);
		state_is(4'h3);
		`CHK(rd[6], 1'b0)
		// second fault cleared by the fault-reset input
		fault_to_9();
		err_req <= 1'b0;
		set_di(4, 1'b1);
		state_is(4'h3);
		set_di(4, 1'b0);
		// defaults of every operating mode
		for (int m = 0; m < 11; m++) begin
			wrf(DSA_OFS_CTRL, 32'h10 | (m << 8));
			rd_chk(6'h08, 32'h01);
			rd_chk(6'h0C, {24'h0, di2_dflt[m]});
			rd_chk(6'h24, 32'h21);
		end
		wrf(DSA_OFS_CTRL, 32'h10);
		fsel_m = '{8'h01, 8'h04, 8'h16, 8'h17, 8'h02, 8'h22, 8'h23, 8'h21};
		wrf(6'h30, 32'hFFFFFFFF);
		rd_chk(6'h30, 32'h0);
		// random selects against the one-input-per-function model
		for (int k = 0; k < 30; k++) begin
			lfsr = lfsr_next(lfsr);
			i = int'(lfsr[2:0]);
			c = pool[lfsr[10:8]];
			hit = 1'b0;
			foreach (fsel_m[j]) if (j != i && c != 8'h00 && fsel_m[j] == c) hit = 1'b1;
			if (!hit) fsel_m[i] = c;
			wrf(DSA_OFS_FSEL + 6'(4 * i), {24'h0, c});
			rd_chk(DSA_OFS_FSEL + 6'(4 * i), {24'h0, fsel_m[i]});
		end
		end_sim();
	end
endmodule
`default_nettype wire
